/* hw/adcc_top.sv */
// Normal-conversion clock and mode control of a successive-approximation converter.
// Assumes an APB master on clk_sys and an analog core that follows the phase strobes.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "adcc_defs.svh"

module adcc_top
  import adcc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PH_W = 10,
  parameter int CH_W = 4
)
(
  // System
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Scan length from the channel-select block
  input wire logic [CH_W-1:0] scanCount,
  // Analog core strobes
  output logic convClkTick,
  output logic sampleActive,
  output logic convertActive,
  output logic [CH_W-1:0] scanIndex,
  output logic convEndPulse,
  // Events
  output logic convIrqPulse,
  output logic irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  adcc_clkcfg_s clkCfg_reg;
  adcc_mode_s mode_reg;
  logic doneFlag_reg;
  logic busyFlag_reg;
  logic [`ADCC_IRQ_BITS-1:0] irqStat_reg;
  logic [`ADCC_IRQ_BITS-1:0] irqMask_reg;
  logic [31:0] prdata_reg;

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  adcc_state_e state_reg;
  adcc_state_e state_next;
  logic [PH_W-1:0] phase_reg;
  logic [PH_W-1:0] phase_next;
  logic [CH_W-1:0] chan_reg;
  logic [CH_W-1:0] chan_next;
  logic [2:0] interval_reg;
  logic [2:0] interval_next;
  logic convEnd_reg;
  logic convIrq_reg;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic setupRd;
  logic accWr;
  logic accRd;
  logic hitClk;
  logic hitMode;
  logic hitStat;
  logic hitMask;
  logic hitAny;
  logic wrClk;
  logic wrMode;
  logic wrStat;
  logic wrMask;
  logic rdMode;
  logic startReq;
  logic startAccepted;
  logic startRefused;

  // Address hits and qualified strobes; zero wait states
  assign hitClk = (paddr == ADDR_W'(`ADCC_OFS_CLKSET));
  assign hitMode = (paddr == ADDR_W'(`ADCC_OFS_MODE0));
  assign hitStat = (paddr == ADDR_W'(`ADCC_OFS_IRQSTAT));
  assign hitMask = (paddr == ADDR_W'(`ADCC_OFS_IRQMASK));
  assign hitAny = hitClk || hitMode || hitStat || hitMask;
  assign setupRd = psel && !penable && !pwrite;
  assign accWr = psel && penable && pwrite && hitAny;
  assign accRd = psel && penable && !pwrite && hitAny;
  assign wrClk = accWr && hitClk;
  assign wrMode = accWr && hitMode;
  assign wrStat = accWr && hitStat;
  assign wrMask = accWr && hitMask;
  assign rdMode = accRd && hitMode;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hitAny;
  assign prdata = prdata_reg;

  // Start only on a written one; a zero is ignored
  assign startReq = wrMode && pwdata[`ADCC_M0_START_BIT];
  assign startAccepted = startReq && (state_reg == ADCC_IDLE);
  assign startRefused = startReq && (state_reg != ADCC_IDLE);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] rdClk;
  logic [31:0] rdMode0;
  logic [31:0] rdStat;
  logic [31:0] rdMask;
  logic [31:0] rdMux;

  // Reserved bits read as zero, start bit always reads zero
  assign rdClk = {24'h000000, clkCfg_reg.tsh, 1'b0, clkCfg_reg.div};
  assign rdMode0 = {24'h000000, doneFlag_reg, busyFlag_reg, 1'b0,
                    mode_reg.itm, mode_reg.repeatMode, mode_reg.scanMode, 1'b0};
  assign rdStat = {30'h0, irqStat_reg};
  assign rdMask = {30'h0, irqMask_reg};
  assign rdMux = hitClk ? rdClk :
                 hitMode ? rdMode0 :
                 hitStat ? rdStat :
                 hitMask ? rdMask : 32'h00000000;

  // Read data captured in the setup phase so it stands through the access phase
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      prdata_reg <= 32'h00000000;
    else if (ce && setupRd)
      prdata_reg <= rdMux;
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Divider code is taken as written; software must not touch it mid-conversion
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      clkCfg_reg.tsh <= `ADCC_TSH_RESET;
      clkCfg_reg.div <= `ADCC_DIV_RESET;
    end
    else if (ce && wrClk)
    begin
      clkCfg_reg.tsh <= pwdata[`ADCC_CLK_TSH_LSB +: 4];
      clkCfg_reg.div <= pwdata[`ADCC_CLK_DIV_LSB +: 3];
    end
  end

  // Mode fields written together with the start bit are in force for that start
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      mode_reg <= '0;
    else if (ce && wrMode)
    begin
      mode_reg.itm <= pwdata[`ADCC_M0_ITM_LSB +: 2];
      mode_reg.repeatMode <= pwdata[`ADCC_M0_RPT_BIT];
      mode_reg.scanMode <= pwdata[`ADCC_M0_SCAN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Conversion clock and phase lengths
  // ----------------------------------------------------------------
  logic [PH_W-1:0] sampleLen;
  logic [PH_W-1:0] convLen;
  logic tick;

  // Reserved sample codes fall back to the shortest legal length
  assign sampleLen = (clkCfg_reg.tsh == 4'h9) ? `ADCC_SH_16 :
                     (clkCfg_reg.tsh == 4'hA) ? `ADCC_SH_24 :
                     (clkCfg_reg.tsh == 4'hB) ? `ADCC_SH_32 :
                     (clkCfg_reg.tsh == 4'h3) ? `ADCC_SH_64 :
                     (clkCfg_reg.tsh == 4'hC) ? `ADCC_SH_128 :
                     (clkCfg_reg.tsh == 4'hD) ? `ADCC_SH_512 : `ADCC_SH_8;
  // Convert phase stretched so sample plus convert never drops below the minimum
  assign convLen = (sampleLen + `ADCC_CONV_CLKS < `ADCC_MIN_CONV_CLKS) ?
                   PH_W'(`ADCC_MIN_CONV_CLKS - sampleLen) : `ADCC_CONV_CLKS;

  adcc_prescaler #(
    .CNT_W(4)
  ) u_prescaler (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .restart(startAccepted),
    .divSel(clkCfg_reg.div),
    .tick(tick)
  );

  assign convClkTick = tick;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic sampleDone;
  logic convDone;
  logic lastChan;
  logic passEnd;
  logic stopNow;
  logic fixedRepeat;
  logic [2:0] intervalLast;
  logic intervalHit;
  logic convEvent;

  assign sampleDone = tick && (state_reg == ADCC_SAMPLE) && (phase_reg == sampleLen - PH_W'(1));
  assign convDone = tick && (state_reg == ADCC_CONVERT) && (phase_reg == convLen - PH_W'(1));
  // Fixed mode converts one channel a pass; scan walks scanCount+1 channels
  assign lastChan = !mode_reg.scanMode || (chan_reg == scanCount);
  assign passEnd = convDone && lastChan;
  assign stopNow = passEnd && !mode_reg.repeatMode;
  assign fixedRepeat = mode_reg.repeatMode && !mode_reg.scanMode;
  // Interval 11 is prohibited; treated like every 8 conversions
  assign intervalLast = (mode_reg.itm == 2'b00) ? 3'h0 :
                        (mode_reg.itm == 2'b01) ? 3'h3 : 3'h7;
  assign intervalHit = convDone && (interval_reg == intervalLast);
  assign convEvent = fixedRepeat ? intervalHit : passEnd;

  // Next-state logic
  always_comb
  begin
    state_next = state_reg;
    phase_next = phase_reg;
    chan_next = chan_reg;
    case (state_reg)
      ADCC_IDLE:
      begin
        phase_next = '0;
        chan_next = '0;
        if (startAccepted)
          state_next = ADCC_SAMPLE;
      end
      ADCC_SAMPLE:
      begin
        if (sampleDone)
        begin
          phase_next = '0;
          state_next = ADCC_CONVERT;
        end
        else if (tick)
          phase_next = phase_reg + PH_W'(1);
      end
      ADCC_CONVERT:
      begin
        if (convDone)
        begin
          phase_next = '0;
          chan_next = lastChan ? '0 : chan_reg + CH_W'(1);
          state_next = stopNow ? ADCC_IDLE : ADCC_SAMPLE;
        end
        else if (tick)
          phase_next = phase_reg + PH_W'(1);
      end
      default:
      begin
        phase_next = '0;
        chan_next = '0;
        state_next = ADCC_IDLE;
      end
    endcase
  end

  // Interval counter only runs in fixed repeat mode
  assign interval_next = !fixedRepeat || state_reg == ADCC_IDLE ? 3'h0 :
                         intervalHit ? 3'h0 :
                         convDone ? interval_reg + 3'h1 : interval_reg;

  // Sequencer registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= ADCC_IDLE;
      phase_reg <= '0;
      chan_reg <= '0;
      interval_reg <= 3'h0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      chan_reg <= chan_next;
      interval_reg <= interval_next;
    end
  end

  // End-of-conversion and interrupt strobes, one cycle each
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      convEnd_reg <= 1'b0;
      convIrq_reg <= 1'b0;
    end
    else if (ce)
    begin
      convEnd_reg <= convDone;
      convIrq_reg <= convEvent;
    end
  end

  // ----------------------------------------------------------------
  // Busy and done flags
  // ----------------------------------------------------------------
  // Busy rises with the accepted start and falls at the final conversion end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      busyFlag_reg <= 1'b0;
    else if (ce)
    begin
      if (startAccepted)
        busyFlag_reg <= 1'b1;
      else if (stopNow)
        busyFlag_reg <= 1'b0;
    end
  end

  // Read-to-clear only once the read showed it, so a late completion is kept
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      doneFlag_reg <= 1'b0;
    else if (ce)
    begin
      if (convEvent)
        doneFlag_reg <= 1'b1;
      else if ((rdMode && prdata_reg[`ADCC_M0_DONE_BIT]) || startAccepted)
        doneFlag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [`ADCC_IRQ_BITS-1:0] irqEvents;
  logic [`ADCC_IRQ_BITS-1:0] irqStat_next;

  assign irqEvents = {startRefused, convEvent};
  // Write-one-to-clear, with a fresh event taking priority
  assign irqStat_next = (irqStat_reg & ~(wrStat ? pwdata[`ADCC_IRQ_BITS-1:0] : '0)) | irqEvents;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      irqStat_reg <= '0;
      irqMask_reg <= '0;
    end
    else if (ce)
    begin
      irqStat_reg <= irqStat_next;
      if (wrMask)
        irqMask_reg <= pwdata[`ADCC_IRQ_BITS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the analog core and system
  // ----------------------------------------------------------------
  assign sampleActive = (state_reg == ADCC_SAMPLE);
  assign convertActive = (state_reg == ADCC_CONVERT);
  assign scanIndex = chan_reg;
  assign convEndPulse = convEnd_reg;
  assign convIrqPulse = convIrq_reg;
  assign irq = |(irqStat_reg & irqMask_reg);

endmodule : adcc_top

/* hw/adcc_defs.svh */
// Offsets, field positions, reset values and cycle counts of the converter control block.
// Assumes a 32-bit word-aligned register map behind an APB slave.
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ADCC_OFS_CLKSET 8'h00
`define ADCC_OFS_MODE0 8'h04
`define ADCC_OFS_IRQSTAT 8'h08
`define ADCC_OFS_IRQMASK 8'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADCC_CLK_TSH_LSB 4
`define ADCC_CLK_DIV_LSB 0
`define ADCC_M0_DONE_BIT 7
`define ADCC_M0_BUSY_BIT 6
`define ADCC_M0_ITM_LSB 3
`define ADCC_M0_RPT_BIT 2
`define ADCC_M0_SCAN_BIT 1
`define ADCC_M0_START_BIT 0
`define ADCC_IRQ_CONV_BIT 0
`define ADCC_IRQ_REFUSE_BIT 1

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define ADCC_TSH_RESET 4'h8
`define ADCC_DIV_RESET 3'h0
`define ADCC_IRQ_BITS 2
`define ADCC_CONV_CLKS 10'h026
`define ADCC_MIN_CONV_CLKS 10'h02E
`define ADCC_SH_8 10'h008
`define ADCC_SH_16 10'h010
`define ADCC_SH_24 10'h018
`define ADCC_SH_32 10'h020
`define ADCC_SH_64 10'h040
`define ADCC_SH_128 10'h080
`define ADCC_SH_512 10'h200

`endif

/* hw/adcc_pkg.sv */
// Types shared by the converter control block.
// Assumes adcc_defs.svh supplies the numeric constants.
package adcc_pkg;

  // Conversion clock setting fields
  typedef struct packed {
    logic [3:0] tsh;
    logic [2:0] div;
  } adcc_clkcfg_s;

  // Normal conversion mode fields
  typedef struct packed {
    logic [1:0] itm;
    logic repeatMode;
    logic scanMode;
  } adcc_mode_s;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ADCC_IDLE = 3'b001,
    ADCC_SAMPLE = 3'b010,
    ADCC_CONVERT = 3'b100
  } adcc_state_e;

endpackage : adcc_pkg

/* hw/adcc_prescaler.sv */
// Conversion clock prescaler: one-cycle tick every 1, 2, 4, 8 or 16 system clocks.
// Assumes the divider select is stable while the sequencer runs.
`timescale 1ns/10ps
module adcc_prescaler
  import adcc_pkg::*;
#(
  parameter int CNT_W = 4
)
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic restart,
  input wire logic [2:0] divSel,
  // Tick out
  output logic tick
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] limit;

  // Terminal count per divider code; reserved codes fall back to the slowest rate
  assign limit = (divSel == 3'h0) ? CNT_W'(0) :
                 (divSel == 3'h1) ? CNT_W'(1) :
                 (divSel == 3'h2) ? CNT_W'(3) :
                 (divSel == 3'h3) ? CNT_W'(7) : CNT_W'(15);
  assign tick = ce && !restart && (cnt_reg == limit);
  assign cnt_next = (restart || cnt_reg == limit) ? '0 : cnt_reg + CNT_W'(1);

  // Free-running divider, realigned on each start
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cnt_reg <= '0;
    else if (ce)
      cnt_reg <= cnt_next;
  end

endmodule : adcc_prescaler

/* sim/adcc_props.sv */
// Concurrent checks on the ports of the converter control block.
// Assumes a bind onto adcc_top with its ADDR_W and CH_W handed on.
`timescale 1ns/10ps
`include "adcc_defs.svh"
module adcc_props
  import adcc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CH_W = 4
)
(
  // System
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sequencer side
  input wire logic [CH_W-1:0] scanCount,
  input wire logic convClkTick,
  input wire logic sampleActive,
  input wire logic convertActive,
  input wire logic [CH_W-1:0] scanIndex,
  input wire logic convEndPulse,
  input wire logic convIrqPulse,
  input wire logic irq
);
  localparam int MIN_CLKS = 46;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // Conversion clocks since the last end; a wide count keeps 512-clock samples honest
  logic [10:0] tickCnt_reg;
  logic [10:0] tickCnt_next;
  wire phaseTick = convClkTick && (sampleActive || convertActive);
  wire mapped = (paddr == ADDR_W'(`ADCC_OFS_CLKSET)) || (paddr == ADDR_W'(`ADCC_OFS_MODE0)) ||
    (paddr == ADDR_W'(`ADCC_OFS_IRQSTAT)) || (paddr == ADDR_W'(`ADCC_OFS_IRQMASK));
  assign tickCnt_next = convEndPulse ? {10'h000, phaseTick} : tickCnt_reg + {10'h000, phaseTick};
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      tickCnt_reg <= 11'h000;
    else
      tickCnt_reg <= tickCnt_next;
  end

  sequence modeRead;
    psel && !penable && !pwrite && (paddr == ADDR_W'(`ADCC_OFS_MODE0));
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ready_always_a: assert property (pready) else $error("pready low");
  map_err_a: assert property (psel && penable && !mapped |-> pslverr) else $error("no slverr");
  map_ok_a: assert property (psel && penable && mapped |-> !pslverr) else $error("bad slverr");
  unmapped_zero_a: assert property (psel && !penable && !pwrite && !mapped |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  mode_fields_a: assert property (modeRead |=> !prdata[0] && !prdata[5] && prdata[31:8] == 24'h0)
    else $error("mode read bits wrong");
  busy_read_a: assert property (modeRead ##0 (sampleActive || convertActive) |=> prdata[6])
    else $error("busy flag low while running");
  phase_excl_a: assert property (!(sampleActive && convertActive)) else $error("both phases");
  sample_conv_a: assert property ($fell(sampleActive) |-> convertActive)
    else $error("sample not followed by convert");
  conv_len_a: assert property (convEndPulse |-> tickCnt_reg >= MIN_CLKS)
    else $error("conversion too short");
  end_cause_a: assert property (convEndPulse |-> $past(convertActive) && !$past(convEndPulse))
    else $error("end pulse without convert phase");
  irq_end_a: assert property (convIrqPulse |-> convEndPulse)
    else $error("irq pulse off a conversion end");
  scan_range_a: assert property ((sampleActive || convertActive) |-> scanIndex <= scanCount)
    else $error("scan index out of range");
endmodule : adcc_props

/* sim/adcc_core_model.sv */
// Analog core stand-in: measures the phase strobes of each conversion.
// Assumes the strobes come from the sequencer on clk_sys.
`timescale 1ns/10ps
module adcc_core_model
  import adcc_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Phase strobes
  input wire logic convClkTick,
  input wire logic sampleActive,
  input wire logic convertActive,
  input wire logic convEndPulse,
  // Figures of the last conversion
  output int sampleTicks,
  output int convTicks,
  output int tickGap
);
  int sCnt = 0;
  int cCnt = 0;
  int gapCnt = 0;

  // Ticks per phase; counts restart at each end, so only single-conversion runs are meaningful
  always @(posedge clk_sys)
  begin
    gapCnt <= (convClkTick === 1'b1) ? 1 : gapCnt + 1;
    if (convClkTick === 1'b1 && (sampleActive || convertActive))
      tickGap <= gapCnt;
    if (convEndPulse === 1'b1)
    begin
      sampleTicks <= sCnt;
      convTicks <= cCnt;
      sCnt <= 0;
      cCnt <= 0;
    end
    else if (convClkTick === 1'b1)
    begin
      if (sampleActive === 1'b1)
        sCnt <= sCnt + 1;
      if (convertActive === 1'b1)
        cCnt <= cCnt + 1;
    end
  end
endmodule : adcc_core_model

/* sim/tb.sv */
// Self-checking bench: APB master, pulse counters and a count model of the sequencer.
// Assumes adcc_top, adcc_core_model and adcc_props are compiled before it.
`timescale 1ns/10ps
`include "adcc_defs.svh"
module tb
  import adcc_pkg::*;
;
  logic clk_sys, rst, ce, psel, penable, pwrite, pready, pslverr;
  logic convClkTick, sampleActive, convertActive, convEndPulse, convIrqPulse, irq, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] scanCount, scanIndex;
  int err_count = 0, samples_checked = 0, cycles = 0, endCount = 0, irqCount = 0, seed, i;
  int sampleTicks, convTicks, tickGap;
  logic [3:0] tshTab [8] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'h3, 4'hC, 4'hD, 4'h0};
  logic [2:0] divTab [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0, 3'h7};
  int shTab [8] = '{8, 16, 24, 32, 64, 128, 512, 8};

  adcc_top u_adcc_top (.clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scanCount(scanCount), .convClkTick(convClkTick),
    .sampleActive(sampleActive), .convertActive(convertActive), .scanIndex(scanIndex),
    .convEndPulse(convEndPulse), .convIrqPulse(convIrqPulse), .irq(irq));
  adcc_core_model u_adcc_core_model (.clk_sys(clk_sys), .convClkTick(convClkTick),
    .sampleActive(sampleActive), .convertActive(convertActive), .convEndPulse(convEndPulse),
    .sampleTicks(sampleTicks), .convTicks(convTicks), .tickGap(tickGap));

  // ----------------------------------------------------------------
  // Clock, timeout and pulse counters
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    endCount <= endCount + (convEndPulse === 1'b1);
    irqCount <= irqCount + (convIrqPulse === 1'b1);
    if (cycles == 60000)
    begin
      err_count++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chkReg(input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex)
    begin
      err_count++;
      $display("Error %0t: register exp %h got %h", $time, ex, got);
    end
  endtask : chkReg
  task automatic chkCnt(input int ex, input int got);
    samples_checked++;
    if (got != ex)
    begin
      err_count++;
      $display("Error %0t: count exp %0d got %0d", $time, ex, got);
    end
  endtask : chkCnt
  function automatic logic [31:0] mv(logic dn, logic by, logic [1:0] it, logic rp, logic sc);
    return {24'h0, dn, by, 1'b0, it, rp, sc, 1'b0};
  endfunction : mv
  // Polls busy over the bus; the read that sees idle also carries the done flag
  task automatic pollIdle();
    do
    begin
      apb(1'b0, `ADCC_OFS_MODE0, 32'h0);
    end
    while (rdata[6] !== 1'b0);
  endtask : pollIdle
  task automatic irqIs(input logic ex);
    repeat (2) @(posedge clk_sys);
    chkReg({31'h0, ex}, {31'h0, irq});
  endtask : irqIs
  task automatic runSingle(input logic [3:0] tsh, input logic [2:0] dv, input int expS);
    int rnd;
    rnd = $random(seed);
    apb(1'b1, `ADCC_OFS_CLKSET, {rnd[31:8], tsh, rnd[3], dv});
    apb(1'b0, `ADCC_OFS_CLKSET, 32'h0);
    chkReg({24'h0, tsh, 1'b0, dv}, rdata);
    apb(1'b1, `ADCC_OFS_MODE0, 32'h0);
    apb(1'b1, `ADCC_OFS_MODE0, 32'h1);
    apb(1'b0, `ADCC_OFS_MODE0, 32'h0);
    chkReg(mv(1'b0, 1'b1, 2'h0, 1'b0, 1'b0), rdata);
    pollIdle();
    chkReg(mv(1'b1, 1'b0, 2'h0, 1'b0, 1'b0), rdata);
    apb(1'b0, `ADCC_OFS_MODE0, 32'h0);
    chkReg(32'h0, rdata);
    chkCnt(expS, sampleTicks);
    chkCnt(int'(`ADCC_CONV_CLKS), convTicks);
    chkCnt((dv > 3'h4) ? 16 : (1 << dv), tickGap);
  endtask : runSingle
  // Count model: passes of scanCount+1 conversions in scan mode and of one in fixed mode, stop lands at the next pass end;
  // the last fixed conversion runs in single mode, so it always interrupts
  task automatic runMode(input logic rp, input logic sc, input logic [1:0] it, input int stopN);
    int e0, i0, k, convs, irqs;
    e0 = endCount;
    i0 = irqCount;
    k = sc ? int'(scanCount) + 1 : 1;
    apb(1'b1, `ADCC_OFS_MODE0, mv(1'b0, 1'b0, it, rp, sc));
    apb(1'b1, `ADCC_OFS_MODE0, mv(1'b0, 1'b0, it, rp, sc) | 32'h1);
    if (rp)
    begin
      apb(1'b1, `ADCC_OFS_MODE0, mv(1'b0, 1'b0, it, rp, sc) | 32'h1);
      while (endCount < e0 + stopN && cycles < 60000) @(posedge clk_sys);
      apb(1'b1, `ADCC_OFS_MODE0, mv(1'b0, 1'b0, it, 1'b0, sc));
    end
    pollIdle();
    repeat (2) @(posedge clk_sys);
    convs = rp ? (stopN / k + 1) * k : k;
    irqs = (rp && !sc) ? stopN / ((it == 2'h0) ? 1 : (it == 2'h1) ? 4 : 8) + 1 : convs / k;
    chkCnt(convs, endCount - e0);
    chkCnt(irqs, irqCount - i0);
  endtask : runMode
  task results;
    $display("Checks %0d, errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 91;
    {rst, ce, psel, penable, pwrite} = 5'b11000;
    paddr = 8'h00;
    pwdata = 32'h0;
    scanCount = 4'h2;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, `ADCC_OFS_CLKSET, 32'h0);
    chkReg(32'h80, rdata);
    for (i = 4; i < 16; i += 4)
    begin
      apb(1'b0, 8'(i), 32'h0);
      chkReg(32'h0, rdata);
    end
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    apb(1'b0, 8'h10, 32'h0);
    chkReg(32'h1, {31'h0, rerr});
    apb(1'b0, `ADCC_OFS_CLKSET, 32'h0);
    chkReg(32'h80, rdata);
    repeat (600) @(posedge clk_sys);
    for (i = 0; i < 8; i++)
      runSingle(tshTab[i], divTab[i], shTab[i]);
    i = {$random(seed)} % 7;
    runSingle(tshTab[i], 3'({$random(seed)} % 5), shTab[i]);
    apb(1'b1, `ADCC_OFS_CLKSET, 32'h80);
    for (i = 0; i < 4; i++)
      runMode(1'b1, 1'b0, 2'(i), 8);
    runMode(1'b1, 1'b1, 2'h1, 6);
    runMode(1'b0, 1'b1, 2'h1, 0);
    runMode(1'b0, 1'b0, 2'h2, 0);
    apb(1'b0, `ADCC_OFS_IRQSTAT, 32'h0);
    chkReg(32'h3, rdata);
    irqIs(1'b0);
    ce <= 1'b0;
    apb(1'b1, `ADCC_OFS_IRQMASK, 32'h3);
    ce <= 1'b1;
    irqIs(1'b0);
    apb(1'b1, `ADCC_OFS_IRQMASK, 32'h2);
    irqIs(1'b1);
    apb(1'b1, `ADCC_OFS_IRQSTAT, 32'h2);
    irqIs(1'b0);
    apb(1'b1, `ADCC_OFS_IRQMASK, 32'h3);
    irqIs(1'b1);
    apb(1'b1, `ADCC_OFS_IRQSTAT, 32'h1);
    irqIs(1'b0);
    runSingle(4'h8, 3'h0, 8);
    irqIs(1'b1);
    results();
  end
endmodule : tb

bind adcc_top adcc_props #(.ADDR_W(ADDR_W), .CH_W(CH_W)) u_adcc_props (.clk_sys(clk_sys),
  .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scanCount(scanCount),
  .convClkTick(convClkTick), .sampleActive(sampleActive), .convertActive(convertActive),
  .scanIndex(scanIndex), .convEndPulse(convEndPulse), .convIrqPulse(convIrqPulse), .irq(irq));
